// file: shared/pic_defs.svh
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH

// source count and register geometry
`define PIC_NUM_SRC       32
`define PIC_ADDR_W        8
`define PIC_OFF_VEC_BASE  8'h80
`define PIC_OFF_PEND      8'h84
`define PIC_OFF_EVSTAT    8'h88
`define PIC_OFF_EVCLR     8'h8C
`define PIC_OFF_EVEN      8'h90
`define PIC_CTRL_SEL      7
`define PIC_CTRL_IDX      6:2

// fields of a source control byte
`define PIC_F_LVL         2:0
`define PIC_F_PRI         4:3
`define PIC_B_AUTO        5
`define PIC_B_RISE        6
`define PIC_B_EN          7

// vector numbers and address shape
`define PIC_AUTOVEC_BASE  8'h18
`define PIC_VEC_SHIFT     2
`define PIC_VEC_BASE_RST  32'h0000_0000
`define PIC_EXT_IDLE      8'hFF
`define PIC_LVL_NONE      3'h0

// event bits
`define PIC_NUM_EV        2
`define PIC_EV_ACK        0
`define PIC_EV_SPUR       1

// AXI responses
`define PIC_RESP_OK       2'b00
`define PIC_RESP_SLVERR   2'b10

`endif

// file: shared/pic_pkg.sv
`include "pic_defs.svh"

package pic_pkg;

    typedef enum logic [1:0] {CS_IDLE, CS_FETCH, CS_ANSWER} pic_cst_t;
    typedef enum logic {CE_RUN, CE_ACK} pic_est_t;

    // winner of one arbitration pass
    typedef struct packed {
        logic       hit;
        logic [4:0] id;
        logic [2:0] lvl;
    } pic_win_t;

    // whole state of the controller end
    typedef struct packed {
        pic_cst_t                        st;
        logic [`PIC_NUM_SRC-1:0][7:0]    ctrl;
        logic [31:0]                     vecBase;
        logic [7:0]                      extPrev;
        logic [7:0]                      extPend;
        logic [4:0]                      ackId;
        logic [2:0]                      ackLvl;
        logic [7:0]                      vecNum;
        logic [31:0]                     vecAddr;
        logic                            ackValid;
        logic                            srcStb;
        logic [2:0]                      ipl;
        logic [`PIC_NUM_EV-1:0]          evStat;
        logic [`PIC_NUM_EV-1:0]          evEn;
        logic                            awGot;
        logic                            wGot;
        logic [`PIC_ADDR_W-1:0]          awAddr;
        logic [31:0]                     wData;
        logic [3:0]                      wStrb;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            rvalid;
        logic [31:0]                     rdata;
        logic [1:0]                      rresp;
    } pic_cs_t;

    // whole state of the core end
    typedef struct packed {
        pic_est_t    st;
        logic [2:0]  mask;
        logic        ackReq;
        logic [2:0]  ackLvl;
        logic        taken;
        logic [7:0]  vecNum;
        logic [31:0] vecAddr;
    } pic_es_t;

endpackage : pic_pkg

// file: shared/pic_link_if.sv
`timescale 1ns/1ps

interface pic_link_if;
    logic [2:0]  ipl;
    logic        ackReq;
    logic [2:0]  ackLevel;
    logic        ackValid;
    logic [7:0]  vecNum;
    logic [31:0] vecAddr;

    modport ctrl (
        output ipl,
        output ackValid,
        output vecNum,
        output vecAddr,
        input  ackReq,
        input  ackLevel
    );

    modport core (
        input  ipl,
        input  ackValid,
        input  vecNum,
        input  vecAddr,
        output ackReq,
        output ackLevel
    );
endinterface : pic_link_if

// file: logic/pic_ctrl.sv
// Function
// - seven levels, taken above mask, after instruction
// - vectoring source returns its vector number
// - autovector sources get fixed level-based entry
// - vector address built from relocatable table base
// - eight active-low external request inputs
// - arbitrate up to 32 sources
// - external inputs edge detected, polarity selectable
// - requester holds request until acknowledge begins
// - three-bit level field per source control
// - software keeps level/priority pairs unique
// - abort line seven: software programs level 7, priority 3, autovector; reset clears it
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_ctrl
    import pic_pkg::*;
#(
    parameter int NUM_EXT = 8
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    pic_link_if.ctrl                    link,
    input  wire logic [NUM_EXT-1:0]     extReqN,
    input  wire logic [`PIC_NUM_SRC-NUM_EXT-1:0] intReq,
    output      logic                   srcAckStb,
    output      logic [4:0]             srcAckId,
    input  wire logic [7:0]             srcVec,
    input  wire logic                   srcVecValid,
    output      logic                   irqOut,
    input  wire logic [`PIC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output      logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output      logic                   s_axi_wready,
    output      logic [1:0]             s_axi_bresp,
    output      logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`PIC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output      logic                   s_axi_arready,
    output      logic [31:0]            s_axi_rdata,
    output      logic [1:0]             s_axi_rresp,
    output      logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready
);

    pic_cs_t q;
    pic_cs_t d;

    logic [`PIC_NUM_SRC-1:0] pend;
    logic [NUM_EXT-1:0]      extEdge;
    logic [NUM_EXT-1:0]      extTake;
    pic_win_t                win;

    // key = {level, priority}; strict compare keeps the lowest index on a tie,
    // which is only reached when software breaks the unique-pair convention
    function automatic pic_win_t pic_pick(input logic [`PIC_NUM_SRC-1:0] p,
                                          input logic [`PIC_NUM_SRC-1:0][7:0] c);
        pic_win_t   w;
        logic [4:0] best;
        logic [4:0] key;
        w    = '0;
        best = '0;
        for (int i = 0; i < `PIC_NUM_SRC; i++) begin
            key = {c[i][`PIC_F_LVL], c[i][`PIC_F_PRI]};
            if (p[i] && c[i][`PIC_B_EN] && c[i][`PIC_F_LVL] != `PIC_LVL_NONE && (!w.hit || key > best)) begin
                w.hit = 1'b1;
                w.id  = 5'(i);
                w.lvl = c[i][`PIC_F_LVL];
                best  = key;
            end
        end
        return w;
    endfunction : pic_pick

    // vector address from the table base, so the table can move
    function automatic logic [31:0] pic_vaddr(input logic [31:0] base, input logic [7:0] vn);
        return base + (32'(vn) << `PIC_VEC_SHIFT);
    endfunction : pic_vaddr

    // byte-lane merge for AXI writes
    function automatic logic [31:0] pic_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : pic_merge

    // external edge detect; pins idle high, falling edge is assertion unless rise is chosen
    always_comb begin
        for (int i = 0; i < NUM_EXT; i++) begin
            extEdge[i] = q.ctrl[i][`PIC_B_RISE] ? (!q.extPrev[i] && extReqN[i])
                                                : (q.extPrev[i] && !extReqN[i]);
        end
    end

    // external lines are latched, internal peripherals are plain levels
    assign pend = {intReq, q.extPend[NUM_EXT-1:0]};
    assign win  = pic_pick(pend, q.ctrl);

    // next-state logic: arbitration, acknowledge sequence, register bus
    always_comb begin
        logic                   doWr;
        logic [`PIC_NUM_EV-1:0] evSet;
        logic [`PIC_NUM_EV-1:0] evClr;
        logic [4:0]             idx;
        doWr    = 1'b0;
        evSet   = '0;
        evClr   = '0;
        idx     = '0;
        extTake = '0;
        d       = q;
        d.srcStb = 1'b0;
        d.extPrev[NUM_EXT-1:0] = extReqN; // unused upper bits keep their idle-high reset
        d.ipl   = win.hit ? win.lvl : `PIC_LVL_NONE;

        // acknowledge sequence with the core
        unique case (q.st)
            CS_IDLE: begin
                if (link.ackReq) begin
                    if (win.hit && win.lvl == link.ackLevel) begin
                        d.ackId  = win.id;
                        d.ackLvl = win.lvl;
                        if (win.id < 5'(NUM_EXT)) begin
                            extTake[win.id[2:0]] = 1'b1;
                        end
                        if (q.ctrl[win.id][`PIC_B_AUTO]) begin
                            d.vecNum   = `PIC_AUTOVEC_BASE + 8'(win.lvl);
                            d.vecAddr  = pic_vaddr(q.vecBase, `PIC_AUTOVEC_BASE + 8'(win.lvl));
                            d.ackValid = 1'b1;
                            d.st       = CS_ANSWER;
                        end else begin
                            d.srcStb = 1'b1;
                            d.st     = CS_FETCH;
                        end
                    end else begin
                        // request vanished before the cycle: answer spurious
                        d.vecNum   = `PIC_AUTOVEC_BASE;
                        d.vecAddr  = pic_vaddr(q.vecBase, `PIC_AUTOVEC_BASE);
                        d.ackValid = 1'b1;
                        evSet[`PIC_EV_SPUR] = 1'b1;
                        d.st       = CS_ANSWER;
                    end
                end
            end
            CS_FETCH: begin
                if (srcVecValid) begin
                    d.vecNum   = srcVec;
                    d.vecAddr  = pic_vaddr(q.vecBase, srcVec);
                    d.ackValid = 1'b1;
                    d.st       = CS_ANSWER;
                end
            end
            CS_ANSWER: begin
                d.ackValid = 1'b0;
                evSet[`PIC_EV_ACK] = 1'b1;
                d.st       = CS_IDLE;
            end
        endcase

        // new edge wins over the take in the same cycle
        d.extPend[NUM_EXT-1:0] = (q.extPend[NUM_EXT-1:0] & ~extTake) | extEdge;

        // AXI write: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            d.awGot  = 1'b1;
            d.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.wGot  = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end
        if (q.awGot && q.wGot) begin
            doWr    = 1'b1;
            d.awGot = 1'b0;
            d.wGot  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `PIC_RESP_OK;
            idx      = q.awAddr[`PIC_CTRL_IDX];
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (doWr) begin
            if (!q.awAddr[`PIC_CTRL_SEL]) begin
                if (q.wStrb[0]) begin
                    d.ctrl[idx] = q.wData[7:0];
                end
            end else if (q.awAddr == `PIC_OFF_VEC_BASE) begin
                d.vecBase = pic_merge(q.vecBase, q.wData, q.wStrb);
            end else if (q.awAddr == `PIC_OFF_EVCLR) begin
                evClr = q.wStrb[0] ? q.wData[`PIC_NUM_EV-1:0] : '0;
            end else if (q.awAddr == `PIC_OFF_EVEN) begin
                if (q.wStrb[0]) begin
                    d.evEn = q.wData[`PIC_NUM_EV-1:0];
                end
            end else begin
                d.bresp = `PIC_RESP_SLVERR;
            end
        end
        // sticky events: a set in the clear cycle survives
        d.evStat = (q.evStat & ~evClr) | evSet;

        // AXI read
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `PIC_RESP_OK;
            d.rdata  = '0;
            if (!s_axi_araddr[`PIC_CTRL_SEL]) begin
                d.rdata[7:0] = q.ctrl[s_axi_araddr[`PIC_CTRL_IDX]];
            end else if (s_axi_araddr == `PIC_OFF_VEC_BASE) begin
                d.rdata = q.vecBase;
            end else if (s_axi_araddr == `PIC_OFF_PEND) begin
                d.rdata = pend;
            end else if (s_axi_araddr == `PIC_OFF_EVSTAT) begin
                d.rdata[`PIC_NUM_EV-1:0] = q.evStat;
            end else if (s_axi_araddr == `PIC_OFF_EVEN) begin
                d.rdata[`PIC_NUM_EV-1:0] = q.evEn;
            end else if (s_axi_araddr != `PIC_OFF_EVCLR) begin
                d.rresp = `PIC_RESP_SLVERR;
            end
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // synchronous reset: every control field to a known value
        if (!rst_n) begin
            d         = '0;
            d.st      = CS_IDLE;
            d.vecBase = `PIC_VEC_BASE_RST;
            d.extPrev = `PIC_EXT_IDLE;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    // outputs
    assign link.ipl      = q.ipl;
    assign link.ackValid = q.ackValid;
    assign link.vecNum   = q.vecNum;
    assign link.vecAddr  = q.vecAddr;
    assign srcAckStb     = q.srcStb;
    assign srcAckId      = q.ackId;
    assign irqOut        = |(q.evStat & q.evEn);
    assign s_axi_awready = !q.awGot && !q.bvalid;
    assign s_axi_wready  = !q.wGot && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

endmodule : pic_ctrl

// file: logic/pic_core_end.sv
`timescale 1ns/1ps
`include "pic_defs.svh"

module pic_core_end
    import pic_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    pic_link_if.core         link,
    input  wire logic        instrDone,
    input  wire logic        maskWr,
    input  wire logic [2:0]  maskVal,
    output      logic [2:0]  curMask,
    output      logic        excTaken,
    output      logic [2:0]  excLevel,
    output      logic [7:0]  excVecNum,
    output      logic [31:0] excVecAddr
);

    pic_es_t q;
    pic_es_t d;

    // take a request only at an instruction boundary and only above the mask
    always_comb begin
        d       = q;
        d.taken = 1'b0;
        unique case (q.st)
            CE_RUN: begin
                if (maskWr) begin
                    d.mask = maskVal;
                end
                if (instrDone && link.ipl > q.mask) begin
                    d.ackReq = 1'b1;
                    d.ackLvl = link.ipl;
                    d.st     = CE_ACK;
                end
            end
            CE_ACK: begin
                // request held until the controller answers
                if (link.ackValid) begin
                    d.ackReq  = 1'b0;
                    d.taken   = 1'b1;
                    d.vecNum  = link.vecNum;
                    d.vecAddr = link.vecAddr;
                    d.mask    = q.ackLvl;
                    d.st      = CE_RUN;
                end
            end
        endcase
        if (!rst_n) begin
            d      = '0;
            d.st   = CE_RUN;
            d.mask = `PIC_LVL_NONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        q <= d;
    end

    assign link.ackReq   = q.ackReq;
    assign link.ackLevel = q.ackLvl;
    assign curMask       = q.mask;
    assign excTaken      = q.taken;
    assign excLevel      = q.ackLvl;
    assign excVecNum     = q.vecNum;
    assign excVecAddr    = q.vecAddr;

endmodule : pic_core_end

// file: dv/pic_link_chk.sv
`timescale 1ns/1ps

module pic_link_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [2:0]  ipl,
    input wire logic        ackReq,
    input wire logic [2:0]  ackLevel,
    input wire logic        ackValid,
    input wire logic [7:0]  vecNum,
    input wire logic [31:0] vecAddr
);
    logic        seen_q;
    logic [31:0] base_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // table base implied by the last answer; software moves it only before acks
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seen_q <= 1'h0;
            base_q <= 32'h0;
        end else if (ackValid) begin
            seen_q <= 1'h1;
            base_q <= vecAddr - {22'h0, vecNum, 2'h0};
        end
    end

    ack_pulse_a: assert property (ackValid |=> !ackValid)
        else $error("answer pulse longer than one cycle");
    answer_cause_a: assert property (ackValid |-> ackReq && $past(ackReq))
        else $error("answer without a standing request");
    req_hold_a: assert property (ackReq && !ackValid |=> ackReq && $stable(ackLevel))
        else $error("request dropped or changed before answer");
    req_release_a: assert property (ackValid |=> !ackReq)
        else $error("request kept after answer");
    req_level_a: assert property ($rose(ackReq) |-> ackLevel == $past(ipl) && ackLevel != 3'h0)
        else $error("request level differs from presented level");
    vec_align_a: assert property (ackValid |-> vecAddr[1:0] == 2'h0)
        else $error("vector address not word aligned");
    vec_hold_a: assert property (ackValid |=> $stable(vecNum) && $stable(vecAddr))
        else $error("vector not held after answer");
    vec_base_a: assert property (ackValid && seen_q |-> vecAddr - {22'h0, vecNum, 2'h0} == base_q)
        else $error("vector address not base plus four times number");

    cover property ($rose(ackReq));
    cover property (ackValid && vecNum == 8'h1F);
    cover property (ackValid && vecNum[7:6] == 2'h1);
endmodule : pic_link_chk

// file: dv/tb.sv
`timescale 1ns/1ps

module tb;
    localparam logic [31:0] VEC_BASE = 32'h0000_1000;
    localparam logic [1:0]  OK  = 2'h0;
    localparam logic [1:0]  ERR = 2'h2;

    logic        clk_sys = 1'h0, rst_n = 1'h0, instrDone = 1'h0, maskWr = 1'h0;
    logic [7:0]  extReqN = 8'hFF, srcVec = 8'h00, awaddr = 8'h00, araddr = 8'h00, excVecNum;
    logic [23:0] intReq = 24'h0;
    logic        srcVecValid = 1'h0, srcAckStb, irqOut, excTaken;
    logic [31:0] wdata = 32'h0, rdata, excVecAddr;
    logic [3:0]  wstrb = 4'hF;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [4:0]  srcAckId;
    logic [2:0]  maskVal = 3'h0, curMask, excLevel;
    int          errors = 0, total_checks = 0;

    pic_link_if pic_link_if_inst ();

    pic_ctrl #(.NUM_EXT(8)) pic_ctrl_inst (.clk_sys, .rst_n, .link(pic_link_if_inst.ctrl), .extReqN, .intReq,
        .srcAckStb, .srcAckId, .srcVec, .srcVecValid, .irqOut, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    pic_core_end pic_core_end_inst (.clk_sys, .rst_n, .link(pic_link_if_inst.core), .instrDone, .maskWr,
        .maskVal, .curMask, .excTaken, .excLevel, .excVecNum, .excVecAddr);

    pic_link_chk pic_link_chk_inst (.clk_sys, .rst_n, .ipl(pic_link_if_inst.ipl),
        .ackReq(pic_link_if_inst.ackReq), .ackLevel(pic_link_if_inst.ackLevel),
        .ackValid(pic_link_if_inst.ackValid), .vecNum(pic_link_if_inst.vecNum),
        .vecAddr(pic_link_if_inst.vecAddr));

    // free running system clock
    initial forever #5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // address and data offered together, each dropped once taken;
    // bready and rready stay high between transfers, so no signal is driven twice in one step
    task automatic axW(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        chk(bresp, er);
    endtask : axW

    task automatic axR(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        chk(rdata, ed);
        chk(rresp, er);
    endtask : axR

    // extra cycles let the presented level catch up with the latest request changes
    task automatic setMask(input logic [2:0] m);
        maskWr <= 1'h1;
        maskVal <= m;
        @(posedge clk_sys);
        maskWr <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask : setMask

    // one instruction boundary, then expect an exception or none
    task automatic ack(input logic tk, input logic [2:0] lv, input logic [7:0] vn);
        logic seen;
        seen = 1'h0;
        instrDone <= 1'h1;
        @(posedge clk_sys);
        instrDone <= 1'h0;
        for (int i = 0; i < 20 && !seen; i++) begin
            @(posedge clk_sys);
            seen = (excTaken === 1'h1);
        end
        chk({31'h0, seen}, {31'h0, tk});
        if (tk) begin
            chk({29'h0, excLevel}, {29'h0, lv});
            chk({24'h0, excVecNum}, {24'h0, vn});
            chk(excVecAddr, VEC_BASE + {22'h0, vn, 2'h0});
            chk({29'h0, curMask}, {29'h0, lv});
        end
    endtask : ack

    // vectored source: stalls two cycles, answers with 0x40 plus its id
    initial forever begin
        @(posedge clk_sys);
        if (srcAckStb === 1'h1) begin
            srcVec <= 8'h40 + {3'h0, srcAckId};
            repeat (2) @(posedge clk_sys);
            srcVecValid <= 1'h1;
            @(posedge clk_sys);
            srcVecValid <= 1'h0;
            srcVec <= ~srcVec;
        end
    end

    // hang guard, far beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        summarize;
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        axR(8'h80, 32'h0, OK);
        axW(8'h80, VEC_BASE, OK);
        axR(8'h80, VEC_BASE, OK);
        axR(8'h1C, 32'h0, OK);
        axW(8'h1C, 32'hBF, OK);
        axR(8'h1C, 32'hBF, OK);
        axW(8'h84, 32'h1, ERR);
        axR(8'hA0, 32'h0, ERR);
        axW(8'h90, 32'h3, OK);
        axR(8'h90, 32'h3, OK);
        // abort line held low until acknowledged
        extReqN[7] <= 1'h0;
        @(posedge clk_sys); // edge is latched one cycle before the read can see it
        axR(8'h84, 32'h80, OK);
        ack(1'h1, 3'h7, 8'h1F);
        extReqN[7] <= 1'h1;
        axR(8'h84, 32'h0, OK);
        axR(8'h88, 32'h1, OK);
        chk({31'h0, irqOut}, 32'h1);
        axW(8'h90, 32'h0, OK);
        chk({31'h0, irqOut}, 32'h0);
        axW(8'h90, 32'h3, OK);
        axW(8'h8C, 32'h1, OK);
        chk({31'h0, irqOut}, 32'h0);
        axR(8'h88, 32'h0, OK);
        axR(8'h8C, 32'h0, OK);
        // line 0 on rising edge, vectored level 3
        axW(8'h00, 32'hC3, OK);
        extReqN[0] <= 1'h0;
        axR(8'h84, 32'h0, OK);
        extReqN[0] <= 1'h1;
        @(posedge clk_sys);
        axR(8'h84, 32'h1, OK);
        setMask(3'h3);
        ack(1'h0, 3'h0, 8'h00);
        setMask(3'h2);
        ack(1'h1, 3'h3, 8'h40);
        // internal ids 8,9 vectored level 4 (priority 1,2), id 10 auto level 5
        axW(8'h20, 32'h8C, OK);
        axW(8'h24, 32'h94, OK);
        axW(8'h28, 32'hA5, OK);
        intReq[2:0] <= 3'h7;
        setMask(3'h0);
        ack(1'h1, 3'h5, 8'h1D);
        intReq[2] <= 1'h0;
        setMask(3'h0);
        ack(1'h1, 3'h4, 8'h49);
        intReq[1] <= 1'h0;
        setMask(3'h0);
        ack(1'h1, 3'h4, 8'h48);
        intReq[0] <= 1'h0;
        setMask(3'h0);
        ack(1'h0, 3'h0, 8'h00);
        // request withdrawn before the acknowledge: spurious answer and event
        intReq[0] <= 1'h1;
        setMask(3'h0);
        instrDone <= 1'h1;
        @(posedge clk_sys);
        instrDone <= 1'h0;
        intReq[0] <= 1'h0;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, excTaken}, 32'h1);
        chk({24'h0, excVecNum}, 32'h18);
        chk(excVecAddr, VEC_BASE + 32'h60);
        axR(8'h88, 32'h3, OK);
        summarize;
    end
endmodule : tb
